// ==== pkg/subskip_pkg.sv ====
/*
 * Shared constants for the subtract, skip, table and XOR execution block.
 * Assumes a 32-bit classic Wishbone register bus and 8-bit data.
 */
package subskip_pkg;

	// Register byte offsets on the bus.
	localparam logic [11:0] CMD_OFS = 12'h000;
	localparam logic [11:0] ACC_OFS = 12'h004;
	localparam logic [11:0] FLAGS_OFS = 12'h008;
	localparam logic [11:0] TABLE_POINTER_OFS = 12'h00c;
	localparam logic [11:0] TABLE_HIGH_OFS = 12'h010;
	localparam logic [11:0] EXEC_OFS = 12'h014;
	localparam logic [11:0] PAGE_OFS = 12'h018;
	localparam logic [11:0] MEM_BASE = 12'h100;

	// Command word fields.
	localparam int CMD_ADDR_LSB = 0;
	localparam int CMD_IMM_LSB = 8;
	localparam int CMD_BIT_LSB = 16;
	localparam int CMD_OP_LSB = 24;

	// Flag bit positions in the flags register.
	localparam int FLAG_C = 0;
	localparam int FLAG_HALF_CARRY = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_SIGNED_EXCESS = 3;

	// Execution status bit positions.
	localparam int EXEC_BUSY = 0;
	localparam int EXEC_SKIP = 1;

	localparam logic [7:0] ALL_ONES = 8'hff;
	localparam logic [7:0] ONE_BYTE = 8'h01;

	// Operation codes, numbered from zero in this order.
	typedef enum logic [4:0] {
		no_operation,
		subtract_with_borrow,
		subtract_with_borrow_to_memory,
		plain_subtract,
		plain_subtract_to_memory,
		subtract_immediate,
		decrement_skip_if_zero,
		decrement_skip_if_zero_to_acc,
		increment_skip_if_zero,
		increment_skip_if_zero_to_acc,
		set_byte,
		set_bit,
		skip_if_bit_set,
		skip_if_bit_clear,
		skip_if_zero,
		copy_and_skip_if_zero,
		nibble_exchange,
		nibble_exchange_to_acc,
		table_read_current_page,
		table_read_last_page,
		exclusive_or,
		exclusive_or_to_memory,
		exclusive_or_immediate
	} op_type;

	typedef enum logic [1:0] {st_idle, st_exec, st_dummy, st_table} state_type;

endpackage

// ==== core/subskip_core.sv ====
/*
 * Execution datapath for subtract, decrement/increment-and-skip, bit and zero
 * tests, byte and bit set, nibble exchange, table reads and exclusive-OR.
 * Assumes a classic Wishbone master on mclk_in and a synchronous program
 * memory that returns the word one clock after prog_rd_out with its address.
 */
// Local design decisions: the register addresses and the Wishbone interface to the registers.
// Contract
// RULE1: Borrow subtract puts acc minus operand minus inverted carry in acc, flags updated.
// RULE2: Memory forms of both subtracts write the same difference to memory instead.
// RULE3: Any subtract clears carry on a negative difference and sets it otherwise.
// RULE4: Plain subtract takes acc minus memory or immediate, no borrow, flags updated.
// RULE5: Decrement memory byte, write back, skip if zero, flags untouched.
// RULE6: Accumulator decrement form writes acc only, skips when acc result zero.
// RULE7: Increment memory byte, write back, skip when it wraps to zero, flags untouched.
// RULE8: Accumulator increment form writes acc only, skips when result zero.
// RULE9: A taken skip adds one dummy cycle, making the instruction two cycles.
// RULE10: Byte set writes all ones to memory, flags untouched.
// RULE11: Bit set forces the chosen memory bit high, other bits and flags kept.
// RULE12: Skip when the chosen memory bit is one.
// RULE13: Skip when the chosen memory bit is zero.
// RULE14: Skip when the memory byte is zero, changing nothing.
// RULE15: Copy memory byte to acc, skip when it is zero.
// RULE16: Swap nibbles of the memory byte in place, flags untouched.
// RULE17: Accumulator swap form puts the swapped byte in acc, memory kept.
// RULE18: Current page table read: low byte to memory, high byte to high latch.
// RULE19: Last page table read does the same from the last program page.
// RULE20: XOR of acc with memory or immediate to acc or memory, only zero flag.
// RULE21: Zero on zero result, half-carry from bit 3 borrow, signed overflow flag.
module subskip_core
	import subskip_pkg::*;
#(
	parameter int DEPTH = 64,
	parameter int PAGE_W = 2,
	parameter int PROG_DW = 14
) (
	input wire logic mclk_in, // System clock.
	input wire logic sys_rst_in, // Synchronous reset, active high.
	input wire logic wb_cyc_in, // Bus cycle.
	input wire logic wb_stb_in, // Bus strobe.
	input wire logic wb_we_in, // Bus write.
	input wire logic [11:0] wb_adr_in, // Byte address.
	input wire logic [3:0] wb_sel_in, // Byte lanes.
	input wire logic [31:0] wb_dat_in, // Write data.
	output logic [31:0] wb_dat_out, // Read data.
	output logic wb_ack_out, // Acknowledge.
	output logic [PAGE_W+7:0] prog_addr_out, // Program memory address.
	output logic prog_rd_out, // Program memory read strobe.
	input wire logic [PROG_DW-1:0] prog_data_in, // Program word.
	output logic busy_out, // Instruction in progress.
	output logic skip_out // High during the dummy cycle.
);

	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		state_type st;
		logic [31:0] cmd;
		logic [7:0] acc;
		logic [3:0] flags;
		logic [7:0] table_pointer;
		logic [7:0] table_high;
		logic [PAGE_W-1:0] page;
		logic [PAGE_W+7:0] paddr;
		logic prd;
		logic skip;
		logic last_skip;
		logic ack;
		logic [31:0] rdat;
		logic [DEPTH-1:0][7:0] mem;
	} core_state_type;

	core_state_type q, d;

	// Merges the enabled byte lanes of a write into an old word.
	function automatic logic [31:0] merge_lanes(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// One-hot mask for the selected bit of a byte.
	function automatic logic [7:0] bit_mask(input logic [2:0] idx);
		return ONE_BYTE << idx;
	endfunction

	// Command fields of the instruction held in the command register.
	op_type op;
	logic [AW-1:0] maddr;
	logic [7:0] imm;
	logic [2:0] bsel;
	logic [7:0] opnd;
	assign op = op_type'(q.cmd[CMD_OP_LSB +: 5]);
	assign maddr = q.cmd[CMD_ADDR_LSB +: AW];
	assign imm = q.cmd[CMD_IMM_LSB +: 8];
	assign bsel = q.cmd[CMD_BIT_LSB +: 3];
	assign opnd = q.mem[maddr];

	// Subtractor shared by all subtract forms; carry is an inverted borrow.
	logic use_borrow, use_imm;
	logic [7:0] sub_b;
	logic [8:0] diff9;
	logic [4:0] diff5;
	logic sub_ov;
	assign use_borrow = (op == subtract_with_borrow) || (op == subtract_with_borrow_to_memory); // RULE1
	assign use_imm = (op == subtract_immediate) || (op == exclusive_or_immediate);
	assign sub_b = use_imm ? imm : opnd; // RULE4
	assign diff9 = {1'b0, q.acc} - {1'b0, sub_b} - {8'h00, use_borrow & ~q.flags[FLAG_C]};
	assign diff5 = {1'b0, q.acc[3:0]} - {1'b0, sub_b[3:0]} - {4'h0, use_borrow & ~q.flags[FLAG_C]};
	assign sub_ov = (q.acc[7] ^ sub_b[7]) & (q.acc[7] ^ diff9[7]); // RULE21

	// Bus decode: a request is answered in the cycle after it is seen.
	logic req, wr;
	logic [11:0] mofs;
	logic in_mem;
	assign req = wb_cyc_in & wb_stb_in;
	assign wr = req & wb_we_in & q.ack;
	assign mofs = wb_adr_in - MEM_BASE;
	assign in_mem = (wb_adr_in >= MEM_BASE) && (mofs < 12'(DEPTH * 4));

	// Next-state logic: bus answers, register writes and instruction execution.
	always_comb begin
		logic [7:0] res;
		logic skip;
		res = '0;
		skip = 1'b0;
		d = q;
		d.ack = req & ~q.ack;
		d.skip = 1'b0;
		d.prd = 1'b0;
		if (req & ~q.ack) begin
			d.rdat = '0;
			case (wb_adr_in)
				CMD_OFS: d.rdat = q.cmd;
				ACC_OFS: d.rdat[7:0] = q.acc;
				FLAGS_OFS: d.rdat[3:0] = q.flags;
				TABLE_POINTER_OFS: d.rdat[7:0] = q.table_pointer;
				TABLE_HIGH_OFS: d.rdat[7:0] = q.table_high;
				EXEC_OFS: d.rdat[EXEC_SKIP:EXEC_BUSY] = {q.last_skip, q.st != st_idle};
				PAGE_OFS: d.rdat[PAGE_W-1:0] = q.page;
				default: begin
					if (in_mem) begin
						d.rdat[7:0] = q.mem[mofs[AW+1:2]];
					end
				end
			endcase
		end
		case (q.st)
			st_idle: begin
				// Writes are ignored while an instruction runs, so no state tears.
				if (wr) begin
					case (wb_adr_in)
						CMD_OFS: begin
							d.cmd = merge_lanes(q.cmd, wb_dat_in, wb_sel_in);
							d.st = st_exec;
							// Table address goes out now so the word is back by the second cycle.
							if (d.cmd[CMD_OP_LSB +: 5] == table_read_last_page) begin
								d.paddr = {{PAGE_W{1'b1}}, q.table_pointer}; // RULE19
								d.prd = 1'b1;
							end else if (d.cmd[CMD_OP_LSB +: 5] == table_read_current_page) begin
								d.paddr = {q.page, q.table_pointer}; // RULE18
								d.prd = 1'b1;
							end
						end
						ACC_OFS: if (wb_sel_in[0]) d.acc = wb_dat_in[7:0];
						FLAGS_OFS: if (wb_sel_in[0]) d.flags = wb_dat_in[3:0];
						TABLE_POINTER_OFS: if (wb_sel_in[0]) d.table_pointer = wb_dat_in[7:0];
						PAGE_OFS: if (wb_sel_in[0]) d.page = wb_dat_in[PAGE_W-1:0];
						default: begin
							if (in_mem && wb_sel_in[0]) begin
								d.mem[mofs[AW+1:2]] = wb_dat_in[7:0];
							end
						end
					endcase
				end
			end
			st_exec: begin
				d.st = st_idle;
				case (op)
					subtract_with_borrow, plain_subtract, subtract_immediate: begin
						d.acc = diff9[7:0]; // RULE1 RULE4
					end
					subtract_with_borrow_to_memory, plain_subtract_to_memory: begin
						d.mem[maddr] = diff9[7:0]; // RULE2
					end
					decrement_skip_if_zero: begin
						res = opnd - ONE_BYTE;
						d.mem[maddr] = res; // RULE5
						skip = (res == 8'h00);
					end
					decrement_skip_if_zero_to_acc: begin
						res = opnd - ONE_BYTE;
						d.acc = res; // RULE6
						skip = (res == 8'h00);
					end
					increment_skip_if_zero: begin
						res = opnd + ONE_BYTE;
						d.mem[maddr] = res; // RULE7
						skip = (res == 8'h00);
					end
					increment_skip_if_zero_to_acc: begin
						res = opnd + ONE_BYTE;
						d.acc = res; // RULE8
						skip = (res == 8'h00);
					end
					set_byte: d.mem[maddr] = ALL_ONES; // RULE10
					set_bit: d.mem[maddr] = opnd | bit_mask(bsel); // RULE11
					skip_if_bit_set: skip = |(opnd & bit_mask(bsel)); // RULE12
					skip_if_bit_clear: skip = ~|(opnd & bit_mask(bsel)); // RULE13
					skip_if_zero: skip = (opnd == 8'h00); // RULE14
					copy_and_skip_if_zero: begin
						d.acc = opnd; // RULE15
						skip = (opnd == 8'h00);
					end
					nibble_exchange: d.mem[maddr] = {opnd[3:0], opnd[7:4]}; // RULE16
					nibble_exchange_to_acc: d.acc = {opnd[3:0], opnd[7:4]}; // RULE17
					table_read_current_page, table_read_last_page: d.st = st_table;
					exclusive_or, exclusive_or_immediate: begin
						res = q.acc ^ sub_b;
						d.acc = res; // RULE20
						d.flags[FLAG_Z] = (res == 8'h00);
					end
					exclusive_or_to_memory: begin
						res = q.acc ^ opnd;
						d.mem[maddr] = res; // RULE20
						d.flags[FLAG_Z] = (res == 8'h00);
					end
					default: ;
				endcase
				// Only the subtract forms touch carry, half-carry and overflow.
				if (op inside {subtract_with_borrow, subtract_with_borrow_to_memory, plain_subtract,
						plain_subtract_to_memory, subtract_immediate}) begin
					d.flags[FLAG_C] = ~diff9[8]; // RULE3
					d.flags[FLAG_HALF_CARRY] = ~diff5[4]; // RULE21
					d.flags[FLAG_Z] = (diff9[7:0] == 8'h00); // RULE21
					d.flags[FLAG_SIGNED_EXCESS] = sub_ov; // RULE21
				end
				if (skip) begin
					d.st = st_dummy; // RULE9
				end
				d.skip = skip;
				d.last_skip = skip;
			end
			st_dummy: d.st = st_idle; // RULE9
			st_table: begin
				d.mem[maddr] = prog_data_in[7:0]; // RULE18 RULE19
				d.table_high = 8'(prog_data_in[PROG_DW-1:8]);
				d.st = st_idle;
			end
			default: d.st = st_idle;
		endcase
	end

	// The whole state, data memory included, is cleared by reset.
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Outputs come straight from the state register.
	assign wb_dat_out = q.rdat;
	assign wb_ack_out = q.ack;
	assign prog_addr_out = q.paddr;
	assign prog_rd_out = q.prd;
	assign busy_out = q.st != st_idle;
	assign skip_out = q.skip;

	// The checks below follow one instruction from its execute cycle into the next cycle, except a_dummy_len, a_table_high, a_last_page and a_ack_pulse.
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (sys_rst_in);

	logic ex;
	assign ex = q.st == st_exec;

	a_borrow_sub: assert property (ex && op == subtract_with_borrow |=> // RULE1
		q.acc == 8'($past(q.acc) - $past(opnd) - {7'h00, ~$past(q.flags[FLAG_C])}))
		else $error("borrow subtract result wrong");
	a_sub_to_mem: assert property (ex && op == plain_subtract_to_memory |=> // RULE2
		q.mem[$past(maddr)] == 8'($past(q.acc) - $past(opnd)) && $stable(q.acc))
		else $error("memory subtract result wrong");
	a_carry_sense: assert property (ex && op == plain_subtract |=> // RULE3
		q.flags[FLAG_C] == ($past(q.acc) >= $past(opnd)))
		else $error("carry is not an inverted borrow");
	a_sub_imm: assert property (ex && op == subtract_immediate |=> // RULE4
		q.acc == 8'($past(q.acc) - $past(imm)))
		else $error("immediate subtract result wrong");
	a_dec_skip: assert property (ex && op == decrement_skip_if_zero && opnd == ONE_BYTE |=> // RULE5
		q.st == st_dummy && skip_out && $stable(q.flags))
		else $error("decrement to zero did not skip");
	a_inc_acc: assert property (ex && op == increment_skip_if_zero_to_acc |=> // RULE8
		q.acc == 8'($past(opnd) + ONE_BYTE) && q.mem == $past(q.mem))
		else $error("increment to acc wrong");
	a_dummy_len: assert property (ex && d.skip |=> q.st == st_dummy ##1 q.st == st_idle) // RULE9
		else $error("dummy cycle length wrong");
	a_set_byte: assert property (ex && op == set_byte |=> q.mem[$past(maddr)] == ALL_ONES) // RULE10
		else $error("byte set wrong");
	a_bit_clear: assert property (ex && op == skip_if_bit_clear |=> // RULE13
		skip_out == ~$past(opnd[bsel]))
		else $error("bit clear skip wrong");
	a_nibble_swap: assert property (ex && op == nibble_exchange |=> // RULE16
		q.mem[$past(maddr)] == {$past(opnd[3:0]), $past(opnd[7:4])})
		else $error("nibble swap wrong");
	a_table_high: assert property (q.st == st_table |=> // RULE18
		q.table_high == 8'($past(prog_data_in[PROG_DW-1:8])) && !busy_out)
		else $error("table high latch wrong");
	a_xor_zero: assert property (ex && op == exclusive_or |=> // RULE20
		q.flags[FLAG_Z] == ($past(q.acc) == $past(opnd)) && $stable(q.flags[FLAG_C]))
		else $error("xor zero flag wrong");
	a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack held too long");
	a_dec_acc: assert property (ex && op == decrement_skip_if_zero_to_acc |=> // RULE6
		q.acc == 8'($past(opnd) - ONE_BYTE) && q.mem == $past(q.mem) && skip_out == (q.acc == 8'h00))
		else $error("decrement to acc wrong");
	a_inc_mem: assert property (ex && op == increment_skip_if_zero |=> // RULE7
		q.mem[$past(maddr)] == 8'($past(opnd) + ONE_BYTE) && $stable(q.flags))
		else $error("memory increment wrong");
	a_bit_set: assert property (ex && op == set_bit |=> // RULE11
		q.mem[$past(maddr)] == ($past(opnd) | (ONE_BYTE << $past(bsel))) && $stable(q.flags))
		else $error("bit set wrong");
	a_bit_set_skip: assert property (ex && op == skip_if_bit_set |=> // RULE12
		skip_out == $past(opnd[bsel]) && $stable(q.mem))
		else $error("bit set skip wrong");
	a_zero_skip: assert property (ex && op == skip_if_zero |=> // RULE14
		skip_out == ($past(opnd) == 8'h00) && $stable(q.acc) && $stable(q.mem) && $stable(q.flags))
		else $error("zero skip wrong");
	a_copy_zero: assert property (ex && op == copy_and_skip_if_zero |=> // RULE15
		q.acc == $past(opnd) && skip_out == (q.acc == 8'h00))
		else $error("copy and skip wrong");
	a_swap_acc: assert property (ex && op == nibble_exchange_to_acc |=> // RULE17
		q.acc == {$past(opnd[3:0]), $past(opnd[7:4])} && $stable(q.mem))
		else $error("nibble swap to acc wrong");
	a_last_page: assert property (ex && op == table_read_last_page |-> // RULE19
		prog_addr_out[PAGE_W+7:8] == {PAGE_W{1'b1}})
		else $error("last page address wrong");

	// Covers for the main scenarios: a taken skip, a table read, a borrow and a wrap to zero.
	c_skip_taken: cover property (ex && d.skip ##1 skip_out);
	c_inc_wrap: cover property (ex && op == increment_skip_if_zero && opnd == ALL_ONES);
	c_table_read: cover property (ex ##1 q.st == st_table ##1 !busy_out);
	c_borrow_neg: cover property (ex && use_borrow && diff9[8]);
	c_bus_write: cover property (wr && wb_adr_in == CMD_OFS);

endmodule

// ==== bench/subskip_core_bench.sv ====
/*
 * Self-checking bench for the subtract, skip, table and XOR block.
 * Assumes the core's own assertions and a synchronous program memory modelled here.
 */
module subskip_core_bench
	import subskip_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_in = 1'h0, sys_rst_in = 1'h1, wb_cyc_in = 1'h0, wb_stb_in = 1'h0, wb_we_in = 1'h0;
	logic [11:0] wb_adr_in = 12'h000;
	logic [3:0] wb_sel_in = 4'hf;
	logic [31:0] wb_dat_in = 32'h0, wb_dat_out, q;
	logic wb_ack_out, prog_rd_out, busy_out, skip_out;
	logic [9:0] prog_addr_out;
	logic [13:0] prog_data_in = 14'h0;
	logic [7:0] m_acc = 8'h00, m_table_high = 8'h00, m_table_pointer = 8'h00, m_mem [64];
	logic [3:0] m_fl = 4'h0;
	logic [1:0] m_page = 2'h0;
	int num_errors = 0, compares = 0, tn = 0;

	subskip_core subskip_core_i (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(wb_cyc_in),
		.wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
		.wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .prog_addr_out(prog_addr_out),
		.prog_rd_out(prog_rd_out), .prog_data_in(prog_data_in), .busy_out(busy_out), .skip_out(skip_out));

	// Program word pattern; the upper bits depend on the page so a wrong page shows up.
	function automatic logic [13:0] rom_word(input logic [9:0] a);
		return {a[9:4], a[7:0] ^ 8'h5a};
	endfunction

	// Clock at 250 MHz.
	initial forever #2 mclk_in = ~mclk_in;

	// Synchronous program memory: it answers a read strobe one clock later and holds the word otherwise.
	always @(posedge mclk_in) if (prog_rd_out) prog_data_in <= rom_word(prog_addr_out);

	// A hang is cut short well beyond the expected run length.
	initial begin
		#120000;
		num_errors++;
		report_and_stop();
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One classic cycle; the request stands until ack is sampled high, and only the watchdog ends a hang.
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk_in);
		wb_cyc_in <= 1'h1;
		wb_stb_in <= 1'h1;
		wb_we_in <= w;
		wb_adr_in <= a;
		wb_dat_in <= d;
		do begin
			@(posedge mclk_in);
			n++;
		end while (wb_ack_out !== 1'h1);
		q = wb_dat_out;
		check("bus ack delay", 32'(n), 32'h2);
		wb_cyc_in <= 1'h0;
		wb_stb_in <= 1'h0;
		wb_we_in <= 1'h0;
	endtask

	task automatic setx(input logic [7:0] a, input logic [3:0] f);
		bus(1'h1, ACC_OFS, {24'h0, a});
		bus(1'h1, FLAGS_OFS, {28'h0, f});
		m_acc = a;
		m_fl = f;
	endtask

	task automatic setm(input int k, input logic [7:0] v);
		bus(1'h1, MEM_BASE + 12'(k * 4), {24'h0, v});
		m_mem[k] = v;
	endtask

	// Predicts the instruction, runs it, then checks timing, status, acc, flags, the addressed byte and the high latch.
	task automatic run(input op_type op, input logic [5:0] ad, input logic [7:0] imm, input logic [2:0] bt);
		logic [7:0] a, m, b, r;
		logic [8:0] d9;
		logic [4:0] d5;
		logic bin, sk, tb;
		logic [13:0] w;
		int n, ns;
		a = m_acc;
		m = m_mem[ad];
		sk = 1'h0;
		tb = 1'h0;
		case (op)
			subtract_with_borrow, subtract_with_borrow_to_memory, plain_subtract, plain_subtract_to_memory,
			subtract_immediate: begin
				bin = (op <= subtract_with_borrow_to_memory) ? ~m_fl[FLAG_C] : 1'h0;
				b = (op == subtract_immediate) ? imm : m;
				d9 = {1'h0, a} - {1'h0, b} - 9'(bin);
				d5 = {1'h0, a[3:0]} - {1'h0, b[3:0]} - 5'(bin);
				r = d9[7:0];
				m_fl = {(a[7] ^ b[7]) & (a[7] ^ r[7]), r == 8'h00, ~d5[4], ~d9[8]};
				if (op == subtract_with_borrow_to_memory || op == plain_subtract_to_memory) m_mem[ad] = r;
				else m_acc = r;
			end
			decrement_skip_if_zero, decrement_skip_if_zero_to_acc, increment_skip_if_zero,
			increment_skip_if_zero_to_acc: begin
				r = (op < increment_skip_if_zero) ? m - 8'h01 : m + 8'h01;
				sk = r == 8'h00;
				if (op == decrement_skip_if_zero || op == increment_skip_if_zero) m_mem[ad] = r;
				else m_acc = r;
			end
			set_byte: m_mem[ad] = 8'hff;
			set_bit: m_mem[ad][bt] = 1'h1;
			skip_if_bit_set: sk = m[bt];
			skip_if_bit_clear: sk = ~m[bt];
			skip_if_zero: sk = m == 8'h00;
			copy_and_skip_if_zero: begin
				m_acc = m;
				sk = m == 8'h00;
			end
			nibble_exchange: m_mem[ad] = {m[3:0], m[7:4]};
			nibble_exchange_to_acc: m_acc = {m[3:0], m[7:4]};
			table_read_current_page, table_read_last_page: begin
				tb = 1'h1;
				w = rom_word({(op == table_read_last_page) ? 2'h3 : m_page, m_table_pointer});
				m_mem[ad] = w[7:0];
				m_table_high = {2'h0, w[13:8]};
			end
			exclusive_or, exclusive_or_to_memory, exclusive_or_immediate: begin
				r = a ^ ((op == exclusive_or_immediate) ? imm : m);
				m_fl[FLAG_Z] = r == 8'h00;
				if (op == exclusive_or_to_memory) m_mem[ad] = r;
				else m_acc = r;
			end
			default: ;
		endcase
		bus(1'h1, CMD_OFS, {3'h0, op, 5'h0, bt, imm, 2'h0, ad});
		n = 0;
		ns = 0;
		do begin
			@(posedge mclk_in);
			n += int'(busy_out === 1'h1);
			ns += int'(skip_out === 1'h1);
		end while (busy_out === 1'h1 && n < 5);
		check("busy cycles", 32'(n), (sk || tb) ? 32'h2 : 32'h1);
		check("dummy cycles", 32'(ns), {31'h0, sk});
		bus(1'h0, EXEC_OFS, 32'h0);
		check("status", q, {30'h0, sk, 1'h0});
		bus(1'h0, ACC_OFS, 32'h0);
		check("acc", q, {24'h0, m_acc});
		bus(1'h0, FLAGS_OFS, 32'h0);
		check("flags", q, {28'h0, m_fl});
		bus(1'h0, MEM_BASE + 12'(ad * 4), 32'h0);
		check("mem", q, {24'h0, m_mem[ad]});
		bus(1'h0, TABLE_HIGH_OFS, 32'h0);
		check("table high", q, {24'h0, m_table_high});
		tn++;
		$display("test %0d finished", tn);
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Main sequence: awkward values first, then every remaining op code.
	initial begin
		repeat (2) @(posedge mclk_in);
		sys_rst_in <= 1'h0;
		bus(1'h0, 12'h020, 32'h0);
		check("unmapped", q, 32'h0);
		for (int k = 0; k < 64; k++) setm(k, 8'(k * 32'h25 + 32'h5));
		setx(8'h50, 4'h1); setm(1, 8'h30); run(subtract_with_borrow, 1, 8'h00, 3'h0);
		setx(8'h50, 4'h0); run(subtract_with_borrow, 1, 8'h00, 3'h0);
		setx(8'h80, 4'h0); setm(2, 8'h01); run(subtract_with_borrow_to_memory, 2, 8'h00, 3'h0);
		setx(8'h10, 4'h1); setm(3, 8'h20); run(plain_subtract, 3, 8'h00, 3'h0);
		setx(8'h20, 4'h0); run(plain_subtract_to_memory, 3, 8'h00, 3'h0);
		setx(8'h20, 4'h0); run(subtract_immediate, 0, 8'h21, 3'h0);
		setx(8'h5a, 4'hf); setm(4, 8'h01); run(decrement_skip_if_zero, 4, 8'h00, 3'h0);
		run(decrement_skip_if_zero, 4, 8'h00, 3'h0);
		setm(5, 8'h01); run(decrement_skip_if_zero_to_acc, 5, 8'h00, 3'h0);
		setm(6, 8'hff); run(increment_skip_if_zero, 6, 8'h00, 3'h0);
		run(increment_skip_if_zero, 6, 8'h00, 3'h0);
		setm(7, 8'hff); run(increment_skip_if_zero_to_acc, 7, 8'h00, 3'h0);
		setm(7, 8'h41); run(increment_skip_if_zero_to_acc, 7, 8'h00, 3'h0);
		run(set_byte, 8, 8'h00, 3'h0);
		setm(9, 8'h00);
		for (int k = 0; k < 8; k += 7) run(set_bit, 9, 8'h00, 3'(k));
		setm(10, 8'h41);
		for (int k = 0; k < 8; k += 3) run(skip_if_bit_set, 10, 8'h00, 3'(k));
		for (int k = 0; k < 8; k += 3) run(skip_if_bit_clear, 10, 8'h00, 3'(k));
		for (int k = 0; k < 2; k++) begin
			setm(11, k ? 8'h80 : 8'h00);
			run(skip_if_zero, 11, 8'h00, 3'h0);
			run(copy_and_skip_if_zero, 11, 8'h00, 3'h0);
		end
		setm(12, 8'h1e); run(nibble_exchange, 12, 8'h00, 3'h0);
		run(nibble_exchange_to_acc, 12, 8'h00, 3'h0);
		bus(1'h1, TABLE_POINTER_OFS, 32'ha5); m_table_pointer = 8'ha5;
		bus(1'h1, PAGE_OFS, 32'h1); m_page = 2'h1;
		run(table_read_current_page, 0, 8'h00, 3'h0);
		run(table_read_last_page, 63, 8'h00, 3'h0);
		setx(8'h3c, 4'hb); setm(13, 8'h3c); run(exclusive_or, 13, 8'h00, 3'h0);
		setx(8'h0f, 4'h0); run(exclusive_or_to_memory, 13, 8'h00, 3'h0);
		run(exclusive_or_immediate, 0, 8'hff, 3'h0);
		run(no_operation, 14, 8'h00, 3'h0);
		run(op_type'(5'h17), 14, 8'h00, 3'h0);
		// Sweep for stray writes into bytes that no instruction addressed.
		for (int k = 0; k < 64; k++) begin
			bus(1'h0, MEM_BASE + 12'(k * 4), 32'h0);
			check("sweep", q, {24'h0, m_mem[k]});
		end
		report_and_stop();
	end
endmodule
